// File: common/smpp_pkg.sv
// constants and carrier types of the serial memory programming port
package smpp_pkg;

  // ----------------------------------------------------------------
  // clock and wait times
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS          = 40;
  localparam int FLASH_WRITE_WAIT_NS    = 4_500_000;
  localparam int EEPROM_WRITE_WAIT_NS   = 9_000_000;
  localparam int ERASE_WAIT_NS          = 9_000_000;
  // the device must be done by these times, so the counts round down
  localparam int FLASH_WRITE_WAIT_CYC   = FLASH_WRITE_WAIT_NS / CLK_PERIOD_NS;
  localparam int EEPROM_WRITE_WAIT_CYC  = EEPROM_WRITE_WAIT_NS / CLK_PERIOD_NS;
  localparam int ERASE_WAIT_CYC         = ERASE_WAIT_NS / CLK_PERIOD_NS;
  localparam int BUSY_W                 = 18;

  // ----------------------------------------------------------------
  // memory geometry
  // ----------------------------------------------------------------
  localparam int FLASH_AW               = 12;
  localparam int FLASH_WORDS            = 4096;
  localparam int PAGE_AW                = 6;
  localparam int PAGE_WORDS             = 64;
  localparam int EE_AW                  = 9;
  localparam int EE_BYTES               = 512;
  localparam logic [7:0]  ERASED_BYTE   = 8'hFF;
  localparam logic [15:0] ERASED_WORD   = 16'hFFFF;
  localparam logic [7:0]  IDLE_BYTE     = 8'h00;

  // ----------------------------------------------------------------
  // instruction encoding
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_ENABLE      = 8'hAC;
  localparam logic [7:0] ENABLE_KEY     = 8'h53;
  localparam logic [2:0] ERASE_KEY      = 3'h4;
  localparam logic [7:0] OP_RD_FLASH_LO = 8'h20;
  localparam logic [7:0] OP_RD_FLASH_HI = 8'h28;
  localparam logic [7:0] OP_LD_PAGE_LO  = 8'h40;
  localparam logic [7:0] OP_LD_PAGE_HI  = 8'h48;
  localparam logic [7:0] OP_WR_PAGE     = 8'h4C;
  localparam logic [7:0] OP_RD_EE       = 8'hA0;
  localparam logic [7:0] OP_WR_EE       = 8'hC0;

  // ----------------------------------------------------------------
  // framing
  // ----------------------------------------------------------------
  localparam logic [2:0] BIT_LAST       = 3'h7;
  localparam logic [1:0] IDX_B1         = 2'h0;
  localparam logic [1:0] IDX_B2         = 2'h1;
  localparam logic [1:0] IDX_B3         = 2'h2;
  localparam logic [1:0] IDX_B4         = 2'h3;

  typedef struct packed {
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] b4;
    logic [1:0] last;
  } smpp_frame_t;

  typedef enum logic [1:0] {
    SMPP_IDLE,
    SMPP_FLASH_WR,
    SMPP_EE_WR,
    SMPP_ERASE
  } smpp_busy_t;

endpackage

// File: core/smpp_sync.sv
// two-flop level synchroniser
`timescale 1ns/100ps
module smpp_sync
  import smpp_pkg::*;
#(
  parameter int W = 1
)(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta <= '0;
      q    <= '0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// File: core/smpp_link.sv
// serial shifter on the programmer's clock: framing, echo and reply
`timescale 1ns/100ps
module smpp_link
  import smpp_pkg::*;
(
  input  wire logic        sck,
  input  wire logic        clear,
  input  wire logic        mosi,
  input  wire logic [7:0]  resp,
  output smpp_frame_t      frame,
  output logic             rx_toggle,
  output logic             miso
);

  logic [2:0] bit_cnt;
  logic [1:0] byte_idx;
  logic [6:0] shift_in;
  logic [7:0] out_sh;
  logic [7:0] next_byte;

  assign next_byte = {shift_in, mosi};
  assign miso      = out_sh[7];

  // ----------------------------------------------------------------
  // receive, msb first, four bytes back to back
  // ----------------------------------------------------------------
  // clear comes from a system-domain flop; it only falls while sck is idle
  always_ff @(posedge sck or posedge clear)
  begin
    if (clear)
    begin
      bit_cnt   <= '0;
      byte_idx  <= '0;
      shift_in  <= '0;
      frame     <= '0;
      rx_toggle <= 1'b0;
    end
    else
    begin
      shift_in <= next_byte[6:0];
      bit_cnt  <= bit_cnt + 3'h1;
      if (bit_cnt == BIT_LAST)
      begin
        unique case (byte_idx)
          IDX_B1: frame.b1 <= next_byte;
          IDX_B2: frame.b2 <= next_byte;
          IDX_B3: frame.b3 <= next_byte;
          IDX_B4: frame.b4 <= next_byte;
        endcase
        frame.last <= byte_idx;
        rx_toggle  <= ~rx_toggle;
        byte_idx   <= byte_idx + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // transmit on the falling edge
  // ----------------------------------------------------------------
  always_ff @(negedge sck or posedge clear)
  begin
    if (clear)
      out_sh <= IDLE_BYTE;
    else if (bit_cnt == 3'h0)
    begin
      unique case (byte_idx)
        IDX_B3:  out_sh <= frame.b2;
        IDX_B4:  out_sh <= resp;
        default: out_sh <= IDLE_BYTE;
      endcase
    end
    else
      out_sh <= {out_sh[6:0], 1'b0};
  end

endmodule

// File: core/smpp_top.sv
// serial programming port of the on-chip flash and eeprom
`timescale 1ns/100ps
module smpp_top
  import smpp_pkg::*;
#(
  parameter int FLASH_WR_CYCLES = FLASH_WRITE_WAIT_CYC,
  parameter int EE_WR_CYCLES    = EEPROM_WRITE_WAIT_CYC,
  parameter int ERASE_CYCLES    = ERASE_WAIT_CYC
)(
  input  wire logic CLK_SYS,
  input  wire logic RST,
  input  wire logic PROG_RESET_N,
  input  wire logic SCK,
  input  wire logic MOSI,
  output logic      MISO,
  output logic      PROG_ENABLED,
  output logic      BUSY,
  output logic      RUN_NORMAL
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic                 sess_s;
  logic                 link_clear;
  logic                 tgl_raw;
  logic                 tgl_s;
  logic                 tgl_d;
  logic                 ev;
  smpp_frame_t          frame;
  logic [7:0]           resp;
  logic                 prog_en;
  smpp_busy_t           busy;
  logic [BUSY_W-1:0]    busy_age;
  logic [BUSY_W-1:0]    busy_len;
  logic [FLASH_AW-PAGE_AW-1:0] wr_page;
  logic [EE_AW-1:0]     ee_addr;
  logic                 can_write;
  logic                 do_enable;
  logic                 do_erase;
  logic                 do_load;
  logic                 do_wr_page;
  logic                 do_wr_ee;
  logic                 do_read;
  logic [FLASH_AW-1:0]  rd_faddr;
  logic [EE_AW-1:0]     rd_eaddr;
  logic [PAGE_AW-1:0]   ld_off;
  logic [FLASH_AW-1:0]  wr_faddr;
  logic                 busy_done;
  logic                 flash_masked;
  logic                 ee_masked;
  logic [15:0]          rd_word;
  logic [7:0]           rd_ee;
  logic [7:0]           next_resp;

  logic [15:0]          flash_mem [FLASH_WORDS];
  logic [15:0]          page_buf  [PAGE_WORDS];
  logic [7:0]           ee_mem    [EE_BYTES];

  // ----------------------------------------------------------------
  // crossings
  // ----------------------------------------------------------------
  // the pin is inverted ahead of the first flop so reset reads as no session
  smpp_sync #(
    .W (1)
  ) u_sess_sync (
    .clk (CLK_SYS),
    .rst (RST),
    .d   (~PROG_RESET_N),
    .q   (sess_s)
  );

  smpp_sync #(
    .W (1)
  ) u_tgl_sync (
    .clk (CLK_SYS),
    .rst (RST),
    .d   (tgl_raw),
    .q   (tgl_s)
  );

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      tgl_d <= 1'b0;
    else
      tgl_d <= tgl_s;
  end

  assign ev = tgl_s ^ tgl_d;

  // holds the shifter cleared whenever no session is open; it returns to
  // framing at byte one, which is how a reset pulse resynchronises
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      link_clear <= 1'b1;
    else
      link_clear <= ~sess_s;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      RUN_NORMAL <= 1'b0;
    else
      RUN_NORMAL <= ~sess_s;
  end

  // ----------------------------------------------------------------
  // serial link on SCK
  // ----------------------------------------------------------------
  smpp_link u_link (
    .sck       (SCK),
    .clear     (link_clear),
    .mosi      (MOSI),
    .resp      (resp),
    .frame     (frame),
    .rx_toggle (tgl_raw),
    .miso      (MISO)
  );

  // ----------------------------------------------------------------
  // decode; bytes of a frame stay put until the next frame overwrites them
  // ----------------------------------------------------------------
  assign can_write  = prog_en && sess_s && (busy == SMPP_IDLE);
  assign do_read    = ev && (frame.last == IDX_B3);
  assign do_enable  = ev && sess_s && (frame.last == IDX_B4)
                      && (frame.b1 == OP_ENABLE) && (frame.b2 == ENABLE_KEY);
  assign do_erase   = ev && can_write && (frame.last == IDX_B4)
                      && (frame.b1 == OP_ENABLE) && (frame.b2[7:5] == ERASE_KEY);
  assign do_load    = ev && can_write && (frame.last == IDX_B4)
                      && ((frame.b1 == OP_LD_PAGE_LO) || (frame.b1 == OP_LD_PAGE_HI));
  assign do_wr_page = ev && can_write && (frame.last == IDX_B4)
                      && (frame.b1 == OP_WR_PAGE);
  assign do_wr_ee   = ev && can_write && (frame.last == IDX_B4)
                      && (frame.b1 == OP_WR_EE);

  assign rd_faddr = {frame.b2[3:0], frame.b3};
  assign rd_eaddr = {frame.b2[0], frame.b3};
  assign ld_off   = frame.b3[PAGE_AW-1:0];
  assign wr_faddr = {frame.b2[3:0], frame.b3};

  // ----------------------------------------------------------------
  // session enable
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      prog_en <= 1'b0;
    else if (!sess_s)
      prog_en <= 1'b0;
    else if (do_enable)
      prog_en <= 1'b1;
  end

  assign PROG_ENABLED = prog_en;

  // ----------------------------------------------------------------
  // self-timed operations
  // ----------------------------------------------------------------
  assign busy_done = (busy_age == busy_len - {{(BUSY_W-1){1'b0}}, 1'b1});

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      busy     <= SMPP_IDLE;
      busy_len <= '0;
    end
    else if (do_erase)
    begin
      busy     <= SMPP_ERASE;
      busy_len <= BUSY_W'(ERASE_CYCLES);
    end
    else if (do_wr_page)
    begin
      busy     <= SMPP_FLASH_WR;
      busy_len <= BUSY_W'(FLASH_WR_CYCLES);
    end
    else if (do_wr_ee)
    begin
      busy     <= SMPP_EE_WR;
      busy_len <= BUSY_W'(EE_WR_CYCLES);
    end
    else if ((busy != SMPP_IDLE) && busy_done)
      busy <= SMPP_IDLE;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      busy_age <= '0;
    else if (busy == SMPP_IDLE)
      busy_age <= '0;
    else
      busy_age <= busy_age + {{(BUSY_W-1){1'b0}}, 1'b1};
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      wr_page <= '0;
      ee_addr <= '0;
    end
    else if (do_wr_page)
      wr_page <= wr_faddr[FLASH_AW-1:PAGE_AW];
    else if (do_wr_ee)
      ee_addr <= rd_eaddr;
  end

  assign BUSY = (busy != SMPP_IDLE);

  // ----------------------------------------------------------------
  // page buffer: filled byte by byte, back to all ones once committed
  // ----------------------------------------------------------------
  // the buffer has no reset, so chip erase also sweeps it to all ones;
  // otherwise words never loaded would poison the and with unknowns
  always_ff @(posedge CLK_SYS)
  begin
    if ((busy == SMPP_FLASH_WR || busy == SMPP_ERASE) && busy_age < BUSY_W'(PAGE_WORDS))
      page_buf[busy_age[PAGE_AW-1:0]] <= ERASED_WORD;
    else if (do_load && frame.b1 == OP_LD_PAGE_HI)
      page_buf[ld_off][15:8] <= frame.b4;
    else if (do_load)
      page_buf[ld_off][7:0] <= frame.b4;
  end

  // ----------------------------------------------------------------
  // flash array: one word per cycle over the first cycles of an erase or page write
  // ----------------------------------------------------------------
  // programming can only clear bits, so unloaded words keep their content
  always_ff @(posedge CLK_SYS)
  begin
    if (busy == SMPP_ERASE && busy_age < BUSY_W'(FLASH_WORDS))
      flash_mem[busy_age[FLASH_AW-1:0]] <= ERASED_WORD;
    else if (busy == SMPP_FLASH_WR && busy_age < BUSY_W'(PAGE_WORDS))
      flash_mem[{wr_page, busy_age[PAGE_AW-1:0]}] <=
        flash_mem[{wr_page, busy_age[PAGE_AW-1:0]}]
        & page_buf[busy_age[PAGE_AW-1:0]];
  end

  // ----------------------------------------------------------------
  // eeprom array
  // ----------------------------------------------------------------
  // a plain overwrite is the erase-then-write of the location
  always_ff @(posedge CLK_SYS)
  begin
    if (busy == SMPP_ERASE && busy_age < BUSY_W'(EE_BYTES))
      ee_mem[busy_age[EE_AW-1:0]] <= ERASED_BYTE;
    else if (do_wr_ee)
      ee_mem[rd_eaddr] <= frame.b4;
  end

  // ----------------------------------------------------------------
  // readback for the fourth byte
  // ----------------------------------------------------------------
  assign rd_word = flash_mem[rd_faddr];
  assign rd_ee   = ee_mem[rd_eaddr];

  assign flash_masked = (busy == SMPP_ERASE)
                        || (busy == SMPP_FLASH_WR
                            && rd_faddr[FLASH_AW-1:PAGE_AW] == wr_page);
  assign ee_masked    = (busy == SMPP_ERASE)
                        || (busy == SMPP_EE_WR && rd_eaddr == ee_addr);

  always_comb
  begin
    next_resp = IDLE_BYTE;
    if (prog_en)
    begin
      if (frame.b1 == OP_RD_FLASH_LO)
        next_resp = flash_masked ? ERASED_BYTE : rd_word[7:0];
      else if (frame.b1 == OP_RD_FLASH_HI)
        next_resp = flash_masked ? ERASED_BYTE : rd_word[15:8];
      else if (frame.b1 == OP_RD_EE)
        next_resp = ee_masked ? ERASED_BYTE : rd_ee;
    end
  end

  // cleared at each first byte so a stale value never leaks into a frame
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      resp <= IDLE_BYTE;
    else if (ev && frame.last == IDX_B1)
      resp <= IDLE_BYTE;
    else if (do_read)
      resp <= next_resp;
  end

endmodule

// File: core/smpp_placeholder_none.sv
// intentionally empty: no further design content
`timescale 1ns/100ps

// File: verification/smpp_checker.sv
// concurrent checks on the ports of the serial programming port
`timescale 1ns/100ps
module smpp_checker
  import smpp_pkg::*;
#(
  parameter int FLASH_WR_CYCLES = FLASH_WRITE_WAIT_CYC,
  parameter int EE_WR_CYCLES    = EEPROM_WRITE_WAIT_CYC,
  parameter int ERASE_CYCLES    = ERASE_WAIT_CYC
)(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic PROG_RESET_N,
  input wire logic SCK,
  input wire logic MOSI,
  input wire logic MISO,
  input wire logic PROG_ENABLED,
  input wire logic BUSY,
  input wire logic RUN_NORMAL
);
  logic [BUSY_W-1:0] busy_len;

  // ----------------------------------------------------------------
  // length of the current busy run
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    if (RST || !BUSY)
      busy_len <= '0;
    else
      busy_len <= busy_len + 1'b1;
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  // pin high long enough that the synchroniser has surely followed
  sequence s_pin_high;
    PROG_RESET_N [*8];
  endsequence

  property p_enable_in_session;
    $rose(PROG_ENABLED) |-> !PROG_RESET_N && !RUN_NORMAL;
  endproperty
  property p_busy_when_enabled;
    $rose(BUSY) |-> PROG_ENABLED && !RUN_NORMAL;
  endproperty
  property p_busy_len;
    $fell(BUSY) |-> busy_len == FLASH_WR_CYCLES || busy_len == EE_WR_CYCLES
      || busy_len == ERASE_CYCLES;
  endproperty
  property p_run_on;
    $rose(PROG_RESET_N) |-> ##[1:5] RUN_NORMAL;
  endproperty
  property p_run_off;
    $fell(PROG_RESET_N) |-> ##[1:5] !RUN_NORMAL;
  endproperty
  property p_close_clears;
    s_pin_high |-> !PROG_ENABLED && RUN_NORMAL;
  endproperty
  property p_miso_quiet;
    s_pin_high |-> !MISO;
  endproperty
  property p_miso_on_fall;
    $changed(MISO) |-> !SCK;
  endproperty

  a_enable_in_session: assert property (p_enable_in_session)
    else $error("enable rose outside a session");
  a_busy_when_enabled: assert property (p_busy_when_enabled)
    else $error("operation started without enable");
  a_busy_len: assert property (p_busy_len)
    else $error("busy run has a wrong length");
  a_run_on: assert property (p_run_on)
    else $error("normal run did not follow the pin");
  a_run_off: assert property (p_run_off)
    else $error("normal run did not stop");
  a_close_clears: assert property (p_close_clears)
    else $error("closed session kept its enable");
  a_miso_quiet: assert property (p_miso_quiet)
    else $error("serial out active outside a session");
  a_miso_on_fall: assert property (p_miso_on_fall)
    else $error("serial out moved while the link clock was high");
endmodule

// File: verification/smpp_programmer.sv
// programmer model: master of the serial link
`timescale 1ns/100ps
module smpp_programmer
#(
  parameter int PH = 14
)(
  input  wire logic lclk,
  input  wire logic miso,
  output logic      sck,
  output logic      mosi
);
  initial
  begin
    sck  = 1'b0;
    mosi = 1'b0;
  end

  // always all four bytes, even when the echo is wrong
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    for (int i = 31; i >= 0; i--)
    begin
      @(posedge lclk);
      mosi <= tx[i];
      repeat (PH) @(posedge lclk);
      sck   <= 1'b1;
      rx[i] = miso;
      repeat (PH) @(posedge lclk);
      sck <= 1'b0;
    end
    // clock stands low; data line no longer shows the last bit
    @(posedge lclk);
    mosi <= ~tx[0];
  endtask
endmodule

// File: verification/smpp_top_bench.sv
// self-checking bench of the serial programming port
`timescale 1ns/100ps
module smpp_top_bench;
  import smpp_pkg::*;
  // short waits keep the run small
  localparam int FLW = 600;
  localparam int EEW = 600;
  localparam int ERW = 4200;
  logic        clk_sys      = 1'b0;
  logic        lclk         = 1'b0;
  logic        rst          = 1'b1;
  logic        prog_reset_n = 1'b1;
  logic        sck, mosi, miso, prog_enabled, busy, run_normal;
  logic [31:0] rx;
  int          n_errors     = 0;
  int          checks       = 0;
  int          cycles       = 0;

  always #20 clk_sys = ~clk_sys;
  always #7.5 lclk = ~lclk;

  smpp_top #(.FLASH_WR_CYCLES(FLW), .EE_WR_CYCLES(EEW), .ERASE_CYCLES(ERW)) smpp_top_inst (
    .CLK_SYS(clk_sys), .RST(rst), .PROG_RESET_N(prog_reset_n), .SCK(sck), .MOSI(mosi),
    .MISO(miso), .PROG_ENABLED(prog_enabled), .BUSY(busy), .RUN_NORMAL(run_normal));
  smpp_programmer smpp_programmer_inst (.lclk(lclk), .miso(miso), .sck(sck), .mosi(mosi));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    if (n_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk_flag(input string name, input logic exp, input logic got);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic frame(input logic [31:0] tx);
    smpp_programmer_inst.xfer(tx, rx);
    chk_byte("echo", tx[23:16], rx[15:8]);
  endtask
  task automatic rd(input logic [7:0] op, input logic [11:0] a, input logic [7:0] exp,
                    input string name);
    frame({op, 4'h0, a, 8'h00});
    chk_byte(name, exp, rx[7:0]);
  endtask
  task automatic wait_idle();
    for (int k = 0; k < 5000 && busy !== 1'b0; k++)
      @(posedge clk_sys);
    chk_flag("busy_done", 1'b0, busy);
  endtask
  task automatic set_pin(input logic v);
    @(posedge clk_sys);
    prog_reset_n <= v;
    cyc(10);
  endtask
  task automatic enable();
    frame({OP_ENABLE, ENABLE_KEY, 16'h0000});
    cyc(8);
    chk_flag("prog_enabled", 1'b1, prog_enabled);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_session();
    set_pin(1'b0);
    chk_flag("run_normal", 1'b0, run_normal);
    frame({OP_WR_EE, 16'h0005, 8'h12});
    cyc(8);
    chk_flag("busy", 1'b0, busy);
    enable();
  endtask
  task automatic t_erase();
    frame({OP_ENABLE, 8'h80, 16'h0000});
    cyc(8);
    chk_flag("busy", 1'b1, busy);
    wait_idle();
    rd(OP_RD_FLASH_LO, 12'h047, ERASED_BYTE, "fl_erased");
    rd(OP_RD_EE, 12'h123, ERASED_BYTE, "ee_erased");
  endtask
  task automatic t_eeprom();
    frame({OP_WR_EE, 16'h0123, 8'h5A});
    rd(OP_RD_EE, 12'h123, ERASED_BYTE, "ee_poll");
    wait_idle();
    rd(OP_RD_EE, 12'h123, 8'h5A, "ee_data");
    frame({OP_WR_EE, 16'h0123, 8'hA5});
    wait_idle();
    rd(OP_RD_EE, 12'h123, 8'hA5, "ee_rewrite");
  endtask
  task automatic t_flash();
    frame({OP_LD_PAGE_LO, 16'h0047, 8'hA5});
    frame({OP_LD_PAGE_HI, 16'h0047, 8'hC3});
    frame({OP_WR_PAGE, 16'h0047, 8'h00});
    rd(OP_RD_FLASH_HI, 12'h047, ERASED_BYTE, "fl_poll");
    wait_idle();
    rd(OP_RD_FLASH_LO, 12'h047, 8'hA5, "fl_lo");
    rd(OP_RD_FLASH_HI, 12'h047, 8'hC3, "fl_hi");
    rd(OP_RD_FLASH_LO, 12'h048, ERASED_BYTE, "fl_unloaded");
  endtask
  task automatic t_close();
    set_pin(1'b1);
    chk_flag("run_normal", 1'b1, run_normal);
    chk_flag("prog_enabled", 1'b0, prog_enabled);
    set_pin(1'b0);
    frame({OP_WR_EE, 16'h0123, 8'h00});
    cyc(8);
    chk_flag("busy", 1'b0, busy);
    enable();
    rd(OP_RD_EE, 12'h123, 8'hA5, "ee_kept");
  endtask

  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      n_errors++;
      test_done();
    end
  end

  initial
  begin
    cyc(12);
    rst <= 1'b0;
    cyc(4);
    chk_flag("run_normal", 1'b1, run_normal);
    t_session();
    t_erase();
    t_eeprom();
    t_flash();
    t_close();
    test_done();
  end
endmodule

bind smpp_top smpp_checker #(
  .FLASH_WR_CYCLES(FLASH_WR_CYCLES), .EE_WR_CYCLES(EE_WR_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)
) smpp_checker_inst (
  .CLK_SYS(CLK_SYS), .RST(RST), .PROG_RESET_N(PROG_RESET_N), .SCK(SCK), .MOSI(MOSI),
  .MISO(MISO), .PROG_ENABLED(PROG_ENABLED), .BUSY(BUSY), .RUN_NORMAL(RUN_NORMAL));
